// ==== design/bchr_pkg.sv ====
// package: offsets, field layout and reset values of the bridge header dwords 08h-1ch
package bchr_pkg;
  localparam logic [7:0] OFF_CATEGORY = 8'h08;
  localparam logic [7:0] OFF_LINE_TIMER = 8'h0c;
  localparam logic [7:0] OFF_RSVD_LO = 8'h10;
  localparam logic [7:0] OFF_RSVD_HI = 8'h14;
  localparam logic [7:0] OFF_BUS = 8'h18;
  localparam logic [7:0] OFF_IO = 8'h1c;
  localparam logic [7:0] CATEGORY_PROG_IF = 8'h00;
  localparam logic [7:0] CATEGORY_SUB_CLASS = 8'h04;
  localparam logic [7:0] CATEGORY_BASE_CLASS = 8'h06;
  localparam logic [7:0] LINE_SIZE_MASK = 8'h3c;
  localparam logic [6:0] HEADER_LAYOUT = 7'h01;
  localparam logic [0:0] HEADER_MULTI_FUNC = 1'h0;
  localparam logic [1:0] IO_ADDR_CAP = 2'h1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam int LINE_LSB = 0;
  localparam int PRI_LAT_LSB = 8;
  localparam int HDR_LSB = 16;
  localparam int SEC_LAT_LSB = 24;
  localparam int PRI_BUS_LSB = 0;
  localparam int SEC_BUS_LSB = 8;
  localparam int SUB_BUS_LSB = 16;
  localparam int IO_BASE_LSB = 4;
  localparam int IO_LIMIT_LSB = 12;
  localparam int IO_LIMIT_CAP_LSB = 8;
endpackage

// ==== design/bchr_regs.sv ====
// bridge configuration header dwords 08h through 1ch
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Contract
// - category code reads fixed bridge values
// - line size bits 5:2 writable, reset zero
// - line size bits 1:0, 7:6 read zero
// - primary latency timer writable only reverse
// - secondary latency timer writable only forward
// - header type reads bridge layout, single function
// - offsets 10h-17h reserved, read zero
// - three writable bus numbers at 18h
// - io base low bits read 01, nibble writable
// - io limit low bits read 01, nibble writable
module bchr_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reverse_strap,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_be,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_reverse,
  output logic [7:0] o_pri_bus,
  output logic [7:0] o_sec_bus,
  output logic [7:0] o_sub_bus
);
  typedef struct packed {
    logic strap_done;
    logic reverse;
    logic [3:0] line_size;
    logic [7:0] pri_lat;
    logic [7:0] sec_lat;
    logic [7:0] pri_bus;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic [3:0] io_base;
    logic [3:0] io_limit;
    logic [31:0] rdata;
  } bchr_state_type;

  bchr_state_type s_q;
  bchr_state_type s_d;
  // release chain kept out of the state struct: it alone runs on the raw reset
  logic [1:0] rst_sync_q;
  logic rst_n;

  // composes the dword view of one offset; unmapped and reserved offsets read zero
  function automatic logic [31:0] read_word(input bchr_state_type s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    unique case (a)
      bchr_pkg::OFF_CATEGORY:
        w = {bchr_pkg::CATEGORY_BASE_CLASS, bchr_pkg::CATEGORY_SUB_CLASS, bchr_pkg::CATEGORY_PROG_IF, 8'h00};
      bchr_pkg::OFF_LINE_TIMER:
        w = {8'h00, bchr_pkg::HEADER_MULTI_FUNC, bchr_pkg::HEADER_LAYOUT, s.pri_lat, 2'h0, s.line_size, 2'h0};
      bchr_pkg::OFF_BUS:
        w = {s.sec_lat, s.sub_bus, s.sec_bus, s.pri_bus};
      bchr_pkg::OFF_IO:
        w = {16'h0000, s.io_limit, 2'h0, bchr_pkg::IO_ADDR_CAP, s.io_base, 2'h0, bchr_pkg::IO_ADDR_CAP};
      default:
        w = 32'h0;
    endcase
    return w;
  endfunction

  assign rst_n = rst_sync_q[1];

  always_comb
  begin
    s_d = s_q;
    // the strap is caught once, on the first clock after release, and then frozen
    if (!s_q.strap_done)
    begin
      s_d.reverse = i_reverse_strap;
      s_d.strap_done = 1'b1;
    end
    if (i_wr && i_addr == bchr_pkg::OFF_LINE_TIMER)
    begin
      if (i_be[0])
        s_d.line_size = i_wdata[bchr_pkg::LINE_LSB + 2 +: 4];
      if (i_be[1] && s_q.reverse)
        s_d.pri_lat = i_wdata[bchr_pkg::PRI_LAT_LSB +: 8];
    end
    if (i_wr && i_addr == bchr_pkg::OFF_BUS)
    begin
      if (i_be[0])
        s_d.pri_bus = i_wdata[bchr_pkg::PRI_BUS_LSB +: 8];
      if (i_be[1])
        s_d.sec_bus = i_wdata[bchr_pkg::SEC_BUS_LSB +: 8];
      if (i_be[2])
        s_d.sub_bus = i_wdata[bchr_pkg::SUB_BUS_LSB +: 8];
      if (i_be[3] && !s_q.reverse)
        s_d.sec_lat = i_wdata[bchr_pkg::SEC_LAT_LSB +: 8];
    end
    if (i_wr && i_addr == bchr_pkg::OFF_IO)
    begin
      if (i_be[0])
        s_d.io_base = i_wdata[bchr_pkg::IO_BASE_LSB +: 4];
      if (i_be[1])
        s_d.io_limit = i_wdata[bchr_pkg::IO_LIMIT_LSB +: 4];
    end
    // read data stand exactly one cycle after the strobe, zero otherwise
    s_d.rdata = i_rd ? read_word(s_q, i_addr) : 32'h0;
  end

  // only the sync chain sees the raw reset; all else uses the released copy
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'h1};
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.strap_done <= 1'b0;
      s_q.reverse <= 1'b0;
      s_q.line_size <= bchr_pkg::RST_NIBBLE;
      s_q.pri_lat <= bchr_pkg::RST_BYTE;
      s_q.sec_lat <= bchr_pkg::RST_BYTE;
      s_q.pri_bus <= bchr_pkg::RST_BYTE;
      s_q.sec_bus <= bchr_pkg::RST_BYTE;
      s_q.sub_bus <= bchr_pkg::RST_BYTE;
      s_q.io_base <= bchr_pkg::RST_NIBBLE;
      s_q.io_limit <= bchr_pkg::RST_NIBBLE;
      s_q.rdata <= 32'h0;
    end
    else
    begin
      s_q.strap_done <= s_d.strap_done;
      s_q.reverse <= s_d.reverse;
      s_q.line_size <= s_d.line_size;
      s_q.pri_lat <= s_d.pri_lat;
      s_q.sec_lat <= s_d.sec_lat;
      s_q.pri_bus <= s_d.pri_bus;
      s_q.sec_bus <= s_d.sec_bus;
      s_q.sub_bus <= s_d.sub_bus;
      s_q.io_base <= s_d.io_base;
      s_q.io_limit <= s_d.io_limit;
      s_q.rdata <= s_d.rdata;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_reverse = s_q.reverse;
  assign o_pri_bus = s_q.pri_bus;
  assign o_sec_bus = s_q.sec_bus;
  assign o_sub_bus = s_q.sub_bus;

  sequence seq_rd_cat;
    i_rd && i_addr == bchr_pkg::OFF_CATEGORY;
  endsequence

  sequence seq_wr_bus;
    i_wr && i_addr == bchr_pkg::OFF_BUS && (&i_be);
  endsequence

  AST_CATEGORY: assert property (@(posedge i_clk) disable iff (!rst_n)
    seq_rd_cat |=> o_rdata == 32'h06040000)
    else $error("category code wrong");

  AST_LINE_ZERO: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && i_addr == bchr_pkg::OFF_LINE_TIMER |=> o_rdata[1:0] == 2'h0 && o_rdata[7:6] == 2'h0)
    else $error("unsupported line size bits not zero");

  AST_LINE_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_LINE_TIMER && i_be[0] |=> s_q.line_size == $past(i_wdata[5:2]))
    else $error("line size not written");

  AST_PRI_LAT: assert property (@(posedge i_clk) disable iff (!rst_n)
    !s_q.reverse && s_q.strap_done |-> s_q.pri_lat == 8'h00)
    else $error("primary latency timer written in forward mode");

  AST_SEC_LAT: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_q.reverse && s_q.strap_done |-> s_q.sec_lat == 8'h00)
    else $error("secondary latency timer written in reverse mode");

  AST_HEADER: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && i_addr == bchr_pkg::OFF_LINE_TIMER |=> o_rdata[31:16] == 16'h0001)
    else $error("header layout wrong");

  AST_RESERVED: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && (i_addr == bchr_pkg::OFF_RSVD_LO || i_addr == bchr_pkg::OFF_RSVD_HI) |=> o_rdata == 32'h0)
    else $error("reserved offset not zero");

  AST_BUS_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    seq_wr_bus ##1 (i_rd && i_addr == bchr_pkg::OFF_BUS && !i_wr)
    |=> o_rdata[23:0] == $past(i_wdata[23:0], 2))
    else $error("bus numbers not written");

  AST_IO_CAP: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && i_addr == bchr_pkg::OFF_IO |=> o_rdata[3:0] == 4'h1 && o_rdata[11:8] == 4'h1 && o_rdata[31:16] == 16'h0)
    else $error("io capability bits wrong");

  AST_STRAP_HOLD: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_q.strap_done |=> $stable(s_q.reverse))
    else $error("direction changed after reset");

  AST_NO_BE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_BUS && !i_be[0] |=> $stable(s_q.pri_bus))
    else $error("disabled byte lane written");

  sequence seq_wr_line;
    i_wr && i_addr == bchr_pkg::OFF_LINE_TIMER && i_be[0];
  endsequence

  sequence seq_rd_line;
    i_rd && i_addr == bchr_pkg::OFF_LINE_TIMER && !i_wr;
  endsequence

  sequence seq_wr_io;
    i_wr && i_addr == bchr_pkg::OFF_IO && i_be[0] && i_be[1];
  endsequence

  sequence seq_rd_io;
    i_rd && i_addr == bchr_pkg::OFF_IO && !i_wr;
  endsequence

  AST_PRI_LAT_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_q.reverse && s_q.strap_done && i_wr && i_addr == bchr_pkg::OFF_LINE_TIMER && i_be[1]
    |=> s_q.pri_lat == $past(i_wdata[15:8]))
    else $error("primary latency timer not written in reverse mode");

  AST_PRI_LAT_READ: assert property (@(posedge i_clk) disable iff (!rst_n)
    !s_q.reverse && s_q.strap_done && i_rd && i_addr == bchr_pkg::OFF_LINE_TIMER
    |=> o_rdata[15:8] == 8'h00)
    else $error("primary latency timer not zero in forward mode");

  AST_SEC_LAT_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    !s_q.reverse && s_q.strap_done && i_wr && i_addr == bchr_pkg::OFF_BUS && i_be[3]
    |=> s_q.sec_lat == $past(i_wdata[31:24]))
    else $error("secondary latency timer not written in forward mode");

  AST_SEC_LAT_READ: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_q.reverse && i_rd && i_addr == bchr_pkg::OFF_BUS
    |=> o_rdata[31:24] == 8'h00)
    else $error("secondary latency timer not zero in reverse mode");

  AST_PRI_BUS_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_BUS && i_be[0]
    |=> o_pri_bus == $past(i_wdata[7:0]))
    else $error("primary bus number not written");

  AST_SEC_BUS_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_BUS && i_be[1]
    |=> o_sec_bus == $past(i_wdata[15:8]))
    else $error("secondary bus number not written");

  AST_SUB_BUS_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_BUS && i_be[2]
    |=> o_sub_bus == $past(i_wdata[23:16]))
    else $error("subordinate bus number not written");

  AST_SUB_KEEP: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_BUS && !i_be[2]
    |=> $stable(s_q.sub_bus))
    else $error("subordinate bus number written without its lane");

  AST_IO_BASE_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_IO && i_be[0]
    |=> s_q.io_base == $past(i_wdata[7:4]))
    else $error("io base nibble not written");

  AST_IO_LIMIT_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_IO && i_be[1]
    |=> s_q.io_limit == $past(i_wdata[15:12]))
    else $error("io limit nibble not written");

  AST_IO_KEEP: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_IO && !i_be[1]
    |=> $stable(s_q.io_limit))
    else $error("io limit written without its lane");

  AST_LINE_KEEP: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == bchr_pkg::OFF_LINE_TIMER && !i_be[0]
    |=> $stable(s_q.line_size))
    else $error("line size written without its lane");

  AST_RSVD_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && (i_addr == bchr_pkg::OFF_RSVD_LO || i_addr == bchr_pkg::OFF_RSVD_HI)
    |=> $stable({s_q.line_size, s_q.pri_lat, s_q.sec_lat, s_q.pri_bus})
      && $stable({s_q.sec_bus, s_q.sub_bus, s_q.io_base, s_q.io_limit}))
    else $error("reserved write changed a register");

  AST_LINE_READ: assert property (@(posedge i_clk) disable iff (!rst_n)
    seq_wr_line ##1 seq_rd_line
    |=> o_rdata[5:2] == $past(i_wdata[5:2], 2))
    else $error("line size read back wrong");

  AST_IO_READ: assert property (@(posedge i_clk) disable iff (!rst_n)
    seq_wr_io ##1 seq_rd_io
    |=> o_rdata[7:4] == $past(i_wdata[7:4], 2) && o_rdata[15:12] == $past(i_wdata[15:12], 2))
    else $error("io window read back wrong");

  // checked on the first edge out of reset, before any access can land
  AST_RESET_VALUES: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(rst_n) |-> {s_q.line_size, s_q.pri_lat, s_q.sec_lat, s_q.pri_bus} == 28'h0
      && {s_q.sec_bus, s_q.sub_bus, s_q.io_base, s_q.io_limit} == 24'h0)
    else $error("register not at reset value");

  AST_STRAP_CAPTURE: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(s_q.strap_done) |-> s_q.reverse == $past(i_reverse_strap))
    else $error("direction not taken from the strap");
endmodule // bchr_regs

// ==== dv/testbench.sv ====
// self-checking bench for the bridge header register dwords 08h-1ch
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic rev;
  logic [7:0] pri_bus;
  logic [7:0] sec_bus;
  logic [7:0] sub_bus;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  bchr_regs i_bchr_regs (.i_clk(clk), .i_rst_n(rst_n), .i_reverse_strap(strap), .i_addr(addr),
    .i_wdata(wdata), .i_be(be), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_reverse(rev),
    .o_pri_bus(pri_bus), .o_sec_bus(sec_bus), .o_sub_bus(sub_bus));
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // write then read the same dword with no idle cycle between the strobes
  task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
    input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // strap is only looked at while reset releases, so it is set together with reset
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end
  initial
  begin
    do_reset(1'b0);
    chk({31'h0, rev}, 32'h0);
    // a strap moving after release must not change the direction
    strap <= 1'b1;
    rd_chk(8'h08, 32'h06040000);
    rd_chk(8'h0c, 32'h00010000);
    rd_chk(8'h10, 32'h00000000);
    rd_chk(8'h18, 32'h00000000);
    rd_chk(8'h1c, 32'h00000101);
    wr_reg(8'h08, 32'hffffffff, 4'hf);
    rd_chk(8'h08, 32'h06040000);
    wr_reg(8'h0c, 32'hffffffff, 4'hf);
    rd_chk(8'h0c, 32'h0001003c);
    wr_reg(8'h0c, 32'h00000024, 4'h1);
    rd_chk(8'h0c, 32'h00010024);
    wr_rd_chk(8'h0c, 32'h00000010, 4'h1, 32'h00010010);
    wr_reg(8'h10, 32'hffffffff, 4'hf);
    wr_reg(8'h14, 32'hffffffff, 4'hf);
    rd_chk(8'h10, 32'h00000000);
    rd_chk(8'h14, 32'h00000000);
    wr_reg(8'h18, 32'h44332211, 4'hf);
    rd_chk(8'h18, 32'h44332211);
    chk({8'h00, sub_bus, sec_bus, pri_bus}, 32'h00332211);
    wr_reg(8'h18, 32'haabbccdd, 4'h2);
    rd_chk(8'h18, 32'h4433cc11);
    chk({8'h00, sub_bus, sec_bus, pri_bus}, 32'h0033cc11);
    wr_reg(8'h1c, 32'hffffffff, 4'hf);
    rd_chk(8'h1c, 32'h0000f1f1);
    wr_reg(8'h1c, 32'h00000000, 4'h1);
    rd_chk(8'h1c, 32'h0000f101);
    wr_rd_chk(8'h1c, 32'h00005090, 4'h3, 32'h00005191);
    wr_reg(8'h20, 32'hffffffff, 4'hf);
    rd_chk(8'h20, 32'h00000000);
    chk({31'h0, rev}, 32'h0);
    do_reset(1'b1);
    chk({31'h0, rev}, 32'h1);
    chk({8'h00, sub_bus, sec_bus, pri_bus}, 32'h0);
    rd_chk(8'h0c, 32'h00010000);
    wr_reg(8'h0c, 32'hffffffff, 4'hf);
    rd_chk(8'h0c, 32'h0001ff3c);
    wr_reg(8'h0c, 32'h00005a00, 4'h2);
    rd_chk(8'h0c, 32'h00015a3c);
    wr_reg(8'h18, 32'hffffffff, 4'hf);
    rd_chk(8'h18, 32'h00ffffff);
    wr_rd_chk(8'h18, 32'h55030201, 4'hf, 32'h00030201);
    chk({8'h00, sub_bus, sec_bus, pri_bus}, 32'h00030201);
    rd_chk(8'h1c, 32'h00000101);
    end_of_test();
  end
endmodule // testbench
